// ### rtl/acis_host.sv
// Function
// [R1] address is 110110X0, X from select pin
// [R2] start: data falls while clock high
// [R3] address byte sent msb first
// [R4] device samples data on rising clock
// [R5] data stable while clock high
// [R6] release data, then one ack pulse
// [R7] device holds data low during ack
// [R8] missing address ack aborts the transfer
// [R9] data byte msb first, valid clock high
// [R10] every data byte acked and checked
// [R11] more bytes may follow in one transfer
// [R12] stop: data rises while clock high
// [R13] data line high while bus idle
// [R14] bus clock at most 400 khz
// [R15] prefix 000 mode, 100 volume update
// [R16] gain source and volume mode decode
// [R17] mute and shutdown bit decode
// [R18] select pin low chooses this protocol
// [R19] bridged only if sense and force low
// [R20] beep goes bridged, ignoring mute, headphone
// [R21] other prefixes ignored, registers held
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "acis_defs.svh"
module acis_host
  import acis_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  acis_if.host            bus,
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest
);

  // ----------------------------------------------------------
  // data line synchroniser
  // ----------------------------------------------------------
  logic         sda_m;    // first stage, read only by sda_s
  logic         sda_s;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  // ----------------------------------------------------------
  // quarter-bit divider
  // ----------------------------------------------------------
  // four ticks per bus clock; rounding up keeps scl at or
  // under 400 khz
  localparam logic [5:0] QTR_LAST = 6'(`ACIS_QTR_CYC - 1);  // [R14]

  logic [5:0]   div;
  logic [5:0]   next_div;
  logic         tick;
  logic         accept;    // command taken this cycle

  assign tick = (div == QTR_LAST);

  always_comb begin
    if (tick || accept) begin
      next_div = 6'h00;    // a new command starts a full quarter
    end else begin
      next_div = div + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div <= 6'h00;
    end else begin
      div <= next_div;
    end
  end

  // ----------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------
  acis_hstate_t state;
  logic         busy;
  logic         nack;       // last transfer aborted, no ack
  logic [9:0]   cmd;        // last command: stop, start, byte
  logic         next_wait;
  logic [31:0]  next_rdata;

  assign busy = (state != ACIS_H_IDLE) && (state != ACIS_H_HOLD);

  // waitrequest rests high; it drops for exactly one cycle
  always_comb begin
    next_wait  = 1'b1;
    next_rdata = avs_readdata;
    accept     = 1'b0;
    if (avs_waitrequest && (avs_read || avs_write)) begin
      if (avs_read) begin
        next_wait = 1'b0;
        if (avs_address == `ACIS_REG_STAT) begin
          next_rdata = {30'h0, nack, busy};
        end else if (avs_address == `ACIS_REG_CMD) begin
          next_rdata = {22'h0, cmd};
        end else begin
          next_rdata = 32'h0;  // unmapped reads as zero
        end
      end else if (avs_address != `ACIS_REG_CMD) begin
        next_wait = 1'b0;      // other writes dropped
      end else if (!busy) begin
        // a command write stalls while the bus is busy
        next_wait = 1'b0;
        accept    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
    end
  end

  // ----------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------
  acis_hstate_t next_state;
  logic [1:0]   phase;      // quarter within the bit
  logic [1:0]   next_phase;
  logic [2:0]   bits;       // bits sent of this byte
  logic [2:0]   next_bits;
  logic [7:0]   sbuf;       // byte being shifted out
  logic [7:0]   next_sbuf;
  logic [9:0]   next_cmd;
  logic         next_nack;
  logic         ack_bad;    // data high seen in ack pulse
  logic         next_ack_bad;
  logic         scl;
  logic         next_scl;
  logic         sda_oe;
  logic         next_sda_oe;

  always_comb begin
    next_state   = state;
    next_phase   = phase;
    next_bits    = bits;
    next_sbuf    = sbuf;
    next_cmd     = cmd;
    next_nack    = nack;
    next_ack_bad = ack_bad;
    if (accept) begin
      next_cmd   = avs_writedata[9:0];
      next_sbuf  = avs_writedata[7:0];
      next_nack  = 1'b0;
      next_phase = 2'h0;
      next_bits  = 3'h0;
      // from idle a start is always needed
      if (avs_writedata[`ACIS_CMD_START] || state == ACIS_H_IDLE) begin
        next_state = ACIS_H_START;                        // [R2]
      end else begin
        next_state = ACIS_H_BIT;                          // [R11]
      end
    end else if (tick && busy) begin
      next_phase = phase + 2'h1;
      if (state == ACIS_H_ACK && phase == 2'h2) begin
        next_ack_bad = sda_s;   // sampled late in clock-high
      end
      if (phase == 2'h3) begin
        unique case (state)
          ACIS_H_START: begin
            next_state = ACIS_H_BIT;                      // [R3]
          end
          ACIS_H_BIT: begin
            next_sbuf = {sbuf[6:0], 1'b0};                // [R3] [R9]
            next_bits = bits + 3'h1;
            if (bits == 3'h7) begin
              next_state = ACIS_H_ACK;                    // [R6]
            end
          end
          ACIS_H_ACK: begin
            if (ack_bad) begin
              // no acknowledge: give up and free the bus
              next_nack  = 1'b1;                          // [R8] [R10]
              next_state = ACIS_H_STOP;
            end else if (cmd[`ACIS_CMD_STOP]) begin
              next_state = ACIS_H_STOP;                   // [R12]
            end else begin
              next_state = ACIS_H_HOLD;                   // [R11]
            end
          end
          ACIS_H_STOP: begin
            next_state = ACIS_H_IDLE;                     // [R13]
          end
          ACIS_H_IDLE, ACIS_H_HOLD: begin
            next_state = state;
          end
        endcase
      end
    end
  end

  // line levels follow the next state, so they change only on
  // quarter ticks or when a command is taken; data bits move while scl is low, start and stop edges while it is high
  always_comb begin
    next_scl    = 1'b0;
    next_sda_oe = 1'b0;
    unique case (next_state)
      ACIS_H_IDLE: begin
        next_scl = 1'b1;                                  // [R13]
      end
      ACIS_H_HOLD: begin
        next_scl = 1'b0;          // clock parked low
      end
      ACIS_H_START: begin
        next_scl    = (next_phase == 2'h1) || (next_phase == 2'h2);
        next_sda_oe = next_phase[1];                      // [R2]
      end
      ACIS_H_BIT: begin
        next_scl    = (next_phase == 2'h1) || (next_phase == 2'h2);
        next_sda_oe = ~next_sbuf[7];                      // [R5] [R9]
      end
      ACIS_H_ACK: begin
        next_scl    = (next_phase == 2'h1) || (next_phase == 2'h2);
        next_sda_oe = 1'b0;                               // [R6]
      end
      ACIS_H_STOP: begin
        next_scl    = (next_phase != 2'h0);
        next_sda_oe = ~next_phase[1];                     // [R12]
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= ACIS_H_IDLE;
      phase   <= 2'h0;
      bits    <= 3'h0;
      sbuf    <= 8'h00;
      cmd     <= 10'h000;
      nack    <= 1'b0;
      ack_bad <= 1'b0;
      scl     <= 1'b1;
      sda_oe  <= 1'b0;
    end else begin
      state   <= next_state;
      phase   <= next_phase;
      bits    <= next_bits;
      sbuf    <= next_sbuf;
      cmd     <= next_cmd;
      nack    <= next_nack;
      ack_bad <= next_ack_bad;
      scl     <= next_scl;
      sda_oe  <= next_sda_oe;
    end
  end

  assign bus.scl         = scl;
  assign bus.host_sda_oe = sda_oe;
  assign bus.host_sda_o  = 1'b0;  // open drain: only pulls low

endmodule
`default_nettype wire

// ### rtl/acis_defs.svh
`ifndef ACIS_DEFS_SVH
`define ACIS_DEFS_SVH

// ------------------------------------------------------------
// slave address and command byte layout
// ------------------------------------------------------------
`define ACIS_ADDR_PFX      6'h36   // upper six address bits 110110
`define ACIS_ADDR_RW       1'b0    // only write transfers are answered
`define ACIS_PFX_MODE      3'h0    // top bits of a mode update
`define ACIS_PFX_VOL       3'h4    // top bits of a volume update
`define ACIS_BIT_HPF       4       // headphone force
`define ACIS_BIT_GAIN      3       // gain source
`define ACIS_BIT_VMODE     2       // volume mode
`define ACIS_BIT_MUTE      1       // mute
`define ACIS_BIT_SD        0       // shutdown (low = shut down)
`define ACIS_MODE_RST      5'h00   // shut down, play, fixed volume
`define ACIS_VOL_RST       5'h00   // lowest volume code

// ------------------------------------------------------------
// controller registers (byte addresses on avalon)
// ------------------------------------------------------------
`define ACIS_REG_CMD       4'h0
`define ACIS_REG_STAT      4'h4
`define ACIS_CMD_START     8       // send start before the byte
`define ACIS_CMD_STOP      9       // send stop after the byte
`define ACIS_STAT_BUSY     0
`define ACIS_STAT_NACK     1

// ------------------------------------------------------------
// bus timing
// ------------------------------------------------------------
`define ACIS_CLK_NS        20      // system clock period
`define ACIS_SCL_NS        2500    // least scl period, 400 khz
`define ACIS_QTR_CYC  ((`ACIS_SCL_NS / 4 + `ACIS_CLK_NS - 1) / `ACIS_CLK_NS)

`endif

// ### rtl/acis_pkg.sv
package acis_pkg;

  // device receiver states
  typedef enum logic [4:0] {
    ACIS_D_IDLE = 5'h01,
    ACIS_D_ADDR = 5'h02,
    ACIS_D_ACKA = 5'h04,
    ACIS_D_DATA = 5'h08,
    ACIS_D_ACKD = 5'h10
  } acis_dstate_t;

  // controller sequencer states
  typedef enum logic [5:0] {
    ACIS_H_IDLE  = 6'h01,
    ACIS_H_START = 6'h02,
    ACIS_H_BIT   = 6'h04,
    ACIS_H_ACK   = 6'h08,
    ACIS_H_HOLD  = 6'h10,
    ACIS_H_STOP  = 6'h20
  } acis_hstate_t;

endpackage

// ### rtl/acis_if.sv
`timescale 1ns/1ns
`default_nettype none
interface acis_if;
  logic scl;          // bus clock, driven by the controller only
  logic host_sda_o;   // controller data out (open drain, always 0)
  logic host_sda_oe;  // controller pulls data low
  logic dev_sda_o;    // device data out (open drain, always 0)
  logic dev_sda_oe;   // device pulls data low
  logic sda;          // resolved line, pull-up when nobody drives

  // wired-and of both open-drain drivers
  assign sda = ~((host_sda_oe & ~host_sda_o) |
                 (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev  (input scl, output dev_sda_o, output dev_sda_oe,
                input sda);
endinterface
`default_nettype wire

// ### rtl/acis_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "acis_defs.svh"
module acis_device
  import acis_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  acis_if.dev             bus,
  input  wire logic       addr_select_pin_i,
  input  wire logic       headphone_detect_pin_i,
  input  wire logic       beep_i,
  input  wire logic       spi_select_i,
  output logic            gain_external_o,
  output logic            volume_adjustable_o,
  output logic [4:0]      volume_code_o,
  output logic            mute_o,
  output logic            active_o,
  output logic            bridged_output_o,
  output logic            single_ended_output_o,
  output logic            beep_route_o
);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [5:0]   sync1;      // first stage, read only by sync2
  logic [5:0]   sync2;      // usable pin levels
  logic [1:0]   prev;       // scl/sda one cycle later
  logic         scl_s;
  logic         sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;

  // all six pins are asynchronous to clk_i
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
      prev  <= 2'h3;
    end else begin
      sync1 <= {spi_select_i, beep_i, headphone_detect_pin_i,
                addr_select_pin_i, bus.sda, bus.scl};
      sync2 <= sync1;
      prev  <= sync2[1:0];
    end
  end

  assign scl_s    = sync2[0];
  assign sda_s    = sync2[1];
  assign scl_rise = scl_s & ~prev[0];
  assign scl_fall = ~scl_s & prev[0];
  // start and stop are data edges while the clock is high
  assign start_ev = prev[0] & scl_s & prev[1] & ~sda_s;   // [R2]
  assign stop_ev  = prev[0] & scl_s & ~prev[1] & sda_s;   // [R12]

  // ----------------------------------------------------------
  // receiver
  // ----------------------------------------------------------
  acis_dstate_t state;
  acis_dstate_t next_state;
  logic [3:0]   cnt;         // bits taken in this byte
  logic [3:0]   next_cnt;
  logic [7:0]   shift;       // incoming byte, msb first
  logic [7:0]   next_shift;
  logic         ack_oe;      // pulling data low for acknowledge
  logic         next_ack_oe;
  logic [4:0]   mode;        // output config register, low bits
  logic [4:0]   next_mode;
  logic [4:0]   vol;         // attenuation register, low bits
  logic [4:0]   next_vol;
  logic [7:0]   own_addr;

  // address pin chooses between the two bus addresses
  assign own_addr = {`ACIS_ADDR_PFX, sync2[2], `ACIS_ADDR_RW};  // [R1]

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_shift  = shift;
    next_ack_oe = ack_oe;
    next_mode   = mode;
    next_vol    = vol;
    if (sync2[5]) begin
      // serial peripheral protocol selected, bus ignored
      next_state  = ACIS_D_IDLE;                        // [R18]
      next_ack_oe = 1'b0;
    end else if (start_ev) begin
      // also a repeated start: always compare a new address
      next_state  = ACIS_D_ADDR;                        // [R2]
      next_cnt    = 4'h0;
      next_ack_oe = 1'b0;
    end else if (stop_ev) begin
      next_state  = ACIS_D_IDLE;                        // [R12]
      next_ack_oe = 1'b0;
    end else begin
      unique case (state)
        ACIS_D_IDLE: begin
          next_ack_oe = 1'b0;
        end
        ACIS_D_ADDR, ACIS_D_DATA: begin
          if (scl_rise && cnt != 4'h8) begin
            // sample on the rising clock edge
            next_shift = {shift[6:0], sda_s};           // [R4]
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            if (state == ACIS_D_DATA) begin
              next_ack_oe = 1'b1;                       // [R10]
              next_state  = ACIS_D_ACKD;
              // decode by prefix, other prefixes dropped
              if (shift[7:5] == `ACIS_PFX_MODE) begin
                next_mode = shift[4:0];                 // [R15]
              end else if (shift[7:5] == `ACIS_PFX_VOL) begin
                next_vol = shift[4:0];                  // [R15]
              end                                       // [R21]
            end else if (shift == own_addr) begin
              next_ack_oe = 1'b1;                       // [R7]
              next_state  = ACIS_D_ACKA;
            end else begin
              next_state  = ACIS_D_IDLE;                // [R1]
            end
          end
        end
        ACIS_D_ACKA, ACIS_D_ACKD: begin
          // hold low through the whole ack pulse
          if (scl_fall) begin
            next_ack_oe = 1'b0;                         // [R7]
            next_cnt    = 4'h0;
            next_state  = ACIS_D_DATA;                  // [R11]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state  <= ACIS_D_IDLE;
      cnt    <= 4'h0;
      shift  <= 8'h00;
      ack_oe <= 1'b0;
      mode   <= `ACIS_MODE_RST;
      vol    <= `ACIS_VOL_RST;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      shift  <= next_shift;
      ack_oe <= next_ack_oe;
      mode   <= next_mode;     // held until rewritten [R21]
      vol    <= next_vol;
    end
  end

  assign bus.dev_sda_oe = ack_oe;
  assign bus.dev_sda_o  = 1'b0;   // open drain: only ever pulls low

  // ----------------------------------------------------------
  // amplifier controls
  // ----------------------------------------------------------
  logic [11:0]  ctl;
  logic [11:0]  next_ctl;
  logic         beep;
  logic         bridged;

  assign beep = sync2[4];
  // beep forces the bridged path whatever the headphone state
  assign bridged = beep |                                 // [R20]
                   (~sync2[3] & ~mode[`ACIS_BIT_HPF]);   // [R19]

  always_comb begin
    next_ctl = {mode[`ACIS_BIT_GAIN],                     // [R16]
                mode[`ACIS_BIT_VMODE],                    // [R16]
                vol,
                mode[`ACIS_BIT_MUTE] & ~beep,             // [R17] [R20]
                mode[`ACIS_BIT_SD],                       // [R17]
                bridged,
                ~bridged,                                 // [R19]
                beep};
  end

  // registered so every output comes from a flip-flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl <= 12'h000;
    end else begin
      ctl <= next_ctl;
    end
  end

  assign {gain_external_o, volume_adjustable_o, volume_code_o,
          mute_o, active_o, bridged_output_o,
          single_ended_output_o, beep_route_o} = ctl;

endmodule
`default_nettype wire

// ### dv/acis_chk.sv
`timescale 1ns/1ns
`default_nettype none
module acis_chk
  import acis_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_oe
);
  // ----------------------------------------
  // scl timing helpers
  // ----------------------------------------
  logic       scl_q;         // scl one clock back
  logic [7:0] per_cnt;       // clocks since last scl rise
  logic [7:0] hi_cnt;        // clocks scl has stayed high
  logic [7:0] next_per_cnt;
  logic [7:0] next_hi_cnt;

  // saturating, so a long idle never wraps into a short count
  always_comb begin
    next_per_cnt = (per_cnt == 8'hff) ? per_cnt : per_cnt + 8'h01;
    next_hi_cnt = (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
    if (scl && !scl_q) begin
      next_per_cnt = 8'h01;
    end
    if (!scl) begin
      next_hi_cnt = 8'h00;
    end
  end

  // start full: the first fall after reset follows idle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'b1;
      per_cnt <= 8'hff;
      hi_cnt <= 8'hff;
    end else begin
      scl_q <= scl;
      per_cnt <= next_per_cnt;
      hi_cnt <= next_hi_cnt;
    end
  end

  // ----------------------------------------
  // wire rules
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_start_by_host: assert property (
    scl && $past(scl) && $fell(sda) |-> host_sda_oe ##1 scl [*8])
    else $error("start not made by the host");
  a_stop_then_idle: assert property (
    scl && $past(scl) && $rose(sda) |-> sda [*8])
    else $error("data line not left high after stop");
  a_ack_set_low: assert property (
    $rose(dev_sda_oe) |-> !scl ##1 !scl [*8])
    else $error("ack driven too late in the clock low");
  a_ack_steady: assert property (
    scl && $past(scl) |-> dev_sda_oe == $past(dev_sda_oe))
    else $error("ack changed while clock high");
  a_ack_released: assert property (
    $fell(scl) && dev_sda_oe |-> ##[1:6] !dev_sda_oe)
    else $error("ack held past its pulse");
  a_host_releases: assert property (
    dev_sda_oe && scl |-> !host_sda_oe)
    else $error("host drives data during ack pulse");
  a_scl_period: assert property (
    $rose(scl) |-> per_cnt >= 8'd125)
    else $error("bus clock period too short");
  a_scl_high: assert property (
    $fell(scl) |-> hi_cnt >= 8'd60)
    else $error("bus clock high phase too short");

  c_start: cover property (scl && $fell(sda));
  c_ack: cover property ($rose(dev_sda_oe));
  c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// ### dv/acis_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module acis_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk_i;        // 50 mhz
  logic        rst_b_i;      // active low
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        idp;          // address select pin
  logic        hp;           // headphone present
  logic        bp;           // beep detected
  logic        spi;          // other protocol chosen
  logic        gx, va, mu, ac, br, sg, bt; // device outputs
  logic [4:0]  vol;          // volume code out
  logic [31:0] rd_q;         // last read data
  logic [8:0]  sh;           // last nine bits on the wire
  int          n_errors;
  int          checked;

  acis_if acis_if_i ();
  acis_host acis_host_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus(acis_if_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  acis_device acis_device_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus(acis_if_i),
    .addr_select_pin_i(idp), .headphone_detect_pin_i(hp),
    .beep_i(bp), .spi_select_i(spi), .gain_external_o(gx),
    .volume_adjustable_o(va), .volume_code_o(vol), .mute_o(mu),
    .active_o(ac), .bridged_output_o(br),
    .single_ended_output_o(sg), .beep_route_o(bt));
  acis_chk acis_chk_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl(acis_if_i.scl),
    .sda(acis_if_i.sda), .host_sda_oe(acis_if_i.host_sda_oe),
    .dev_sda_oe(acis_if_i.dev_sda_oe));

  // bits as a receiver latches them on scl rise
  always @(posedge acis_if_i.scl) begin
    sh <= {sh[7:0], acis_if_i.sda};
  end

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; an edge passes first so no double drive
  task avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // no cycle count assumed: only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // one byte, wait until idle or hold, then judge the wire
  task send(input logic [7:0] b, input logic st, sp, ak);
    avs(1'b1, 4'h0, {22'h0, sp, st, b});
    do begin
      avs(1'b0, 4'h4, 32'h0);
    end while (rd_q[0] !== 1'b0);
    chk(32'(rd_q[1]), 32'(ak));
    if (sp || ak) begin
      chk(32'(sh), {23'h0, b[6:0], ak, 1'b0});
      chk(32'({acis_if_i.scl, acis_if_i.sda}), 32'h3);
    end else begin
      chk(32'(sh), {23'h0, b, ak});
    end
  endtask

  // outputs lag pins by three clocks
  task outs(input logic [4:0] m, v);
    logic b2;
    repeat (4) @(posedge clk_i);
    b2 = bp | (!hp && !m[4]);
    chk(32'({gx, va, mu, ac, br, sg, bt, vol}),
        32'({m[3], m[2], m[1] & !bp, m[0], b2, !b2, bp, v}));
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  task stop_test;
    $display("checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    // a write to status is dropped, status stays clear
    avs(1'b1, 4'h4, 32'h3);
    avs(1'b0, 4'h4, 32'h0);
    chk(rd_q, 32'h0);
    avs(1'b0, 4'h8, 32'h0);
    chk(rd_q, 32'h0);
    outs(5'h00, 5'h00);
    done("reset");
  endtask

  task t_mode;
    send(8'hd8, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      send(8'h01 << i, 1'b0, 1'b0, 1'b0);
      outs(5'h01 << i, 5'h00);
    end
    send(8'h95, 1'b0, 1'b1, 1'b0);
    outs(5'h10, 5'h15);
    // command register keeps the last byte and its stop bit
    avs(1'b0, 4'h0, 32'h0);
    chk(rd_q, 32'h295);
    done("mode");
  endtask

  // unknown prefixes acked but change nothing
  task t_ignore;
    // a command written while busy stalls until the hold
    avs(1'b1, 4'h0, {22'h0, 2'b01, 8'hd8});
    avs(1'b0, 4'h4, 32'h0);
    chk(rd_q, 32'h1);
    send(8'hd8, 1'b1, 1'b0, 1'b0);
    for (int p = 1; p < 8; p++) begin
      if (p != 4) begin
        send({3'(p), 5'h0a}, 1'b0, p == 7, 1'b0);
      end
    end
    outs(5'h10, 5'h15);
    done("ignore");
  endtask

  task t_addr;
    send(8'hda, 1'b1, 1'b0, 1'b1);
    send(8'hd9, 1'b1, 1'b0, 1'b1);
    idp <= 1'b1;
    send(8'hd8, 1'b1, 1'b0, 1'b1);
    send(8'hda, 1'b1, 1'b0, 1'b0);
    send(8'h03, 1'b0, 1'b1, 1'b0);
    outs(5'h03, 5'h15);
    done("address");
  endtask

  task t_pins;
    hp <= 1'b1;
    outs(5'h03, 5'h15);
    bp <= 1'b1;
    outs(5'h03, 5'h15);
    hp <= 1'b0;
    bp <= 1'b0;
    done("pins");
  endtask

  task t_spi;
    spi <= 1'b1;
    send(8'hda, 1'b1, 1'b0, 1'b1);
    spi <= 1'b0;
    outs(5'h03, 5'h15);
    done("select");
  endtask

  initial begin
    n_errors = 0;
    checked = 0;
    rst_b_i = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    idp = 1'b0;
    hp = 1'b0;
    bp = 1'b0;
    spi = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_mode;
    t_ignore;
    t_addr;
    t_pins;
    t_spi;
    stop_test;
  end

  // about 21 bytes of 1300 clocks each fit well inside
  initial begin
    #(20 * 80000);
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
